// ===== shared/sss_pkg.sv
// Types shared by the stop sequencer modules
package sss_pkg;
    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_TSC  = 5'h02,
        ST_CUT  = 5'h04,
        ST_TSH  = 5'h08,
        ST_HOLD = 5'h10
    } sss_state_e;
    // Synchronised request and status pins
    typedef struct packed {
        logic estop;
        logic tsc;
        logic tsh;
        logic err;
        logic mute;
        logic inv_still;
        logic ramp_exc;
    } sss_pins_s;
    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic bus_tsh;
        logic bus_tsc;
        logic bus_estop;
        logic special_op;
        logic ramp_en;
        logic enc_present;
        logic mode;
        logic estop_timed;
    } sss_ctrl_s;
endpackage : sss_pkg

// ===== shared/sss_regs.svh
// Register map, field positions, reset values and timing of the stop sequencer
`ifndef SSS_REGS_SVH
`define SSS_REGS_SVH
// Byte offsets on the register bus
`define SSS_CTRL_OFS     8'h00
`define SSS_STOPT_OFS    8'h04
`define SSS_DELAY_OFS    8'h08
`define SSS_TOL_OFS      8'h0c
`define SSS_STAT_OFS     8'h10
`define SSS_ERR_OFS      8'h14
// Status field positions
`define SSS_STAT_ST_LSB  0
`define SSS_STAT_RST_BIT 8
`define SSS_STAT_B15_BIT 15
`define SSS_STAT_ERR_BIT 16
// Error flag positions
`define SSS_ERR_TIME     0
`define SSS_ERR_RAMP     1
`define SSS_ERR_EXT      2
`define SSS_ERR_REFUSE   3
// Reset values
`define SSS_CTRL_RST     8'h00
`define SSS_STOPT_RST    16'h03e8
`define SSS_DELAY_RST    16'h0064
`define SSS_TOL_RST      16'h0010
// Timing: clock period and timer tick, in ns
`define SSS_CLK_NS       50
`define SSS_TICK_NS      1000000
`endif

// ===== tb/sss_drive_model.sv
// Drive and power stage model: speed source for the sequencer
`timescale 1ns/1ps
module sss_drive_model (
    // Clock
    input  wire logic        aclk,
    // Application speed command and torque enable
    input  wire logic        run,
    input  wire logic        torque_en,
    // Speed feedback
    output logic      [15:0] enc_speed,
    output logic             inv_standstill
);
    logic [15:0] spd_reg = 16'h0000;
    // Runs at speed, else the application brakes; coasting when torque is off
    always_ff @(posedge aclk) begin
        if (run && torque_en) spd_reg <= 16'h0200;
        else if (spd_reg > 16'h0008)
            spd_reg <= spd_reg - (torque_en ? 16'h0008 : 16'h0001);
        else spd_reg <= 16'h0000;
    end
    assign enc_speed      = spd_reg;
    assign inv_standstill = spd_reg < 16'h0010; // Inverter standstill status
endmodule : sss_drive_model

// ===== tb/testbench.sv
// Register and stop sequence tests of the stop sequencer
`timescale 1ns/1ps
`include "sss_regs.svh"
module testbench;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic estop = 0, tsc = 0, mute = 0, run = 0, still, torque_en, tsh = 0;
    logic hold_active, stat_b15, err_msg, restart_ok;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [15:0] spd;
    logic [1:0] bresp, rresp;
    int err_total = 0, comparisons = 0, cyc = 0;
    sss_seq #(.TICK_CYCLES(4)) u_sss_seq (.aclk(aclk), .aresetn(aresetn),
        .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .estop_in(estop), .tsc_in(tsc), .tsh_in(tsh), .err_stop_in(1'b0),
        .estop_mute(mute), .inv_standstill(still), .ramp_exceeded(1'b0),
        .enc_speed(spd), .torque_en(torque_en), .hold_active(hold_active),
        .stat_b15(stat_b15), .err_msg(err_msg), .restart_ok(restart_ok));
    sss_drive_model u_sss_drive_model (.aclk(aclk), .run(run),
        .torque_en(torque_en), .enc_speed(spd), .inv_standstill(still));
    always #25 aclk = ~aclk;
    // Watchdog on the whole run
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            finish_test;
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge aclk);
    endtask : wt
    // Write: both channels offered, each dropped when taken
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
        end while (bvalid !== 1'b1);
        bready <= 0;
    endtask : wr
    // Read: returns data and response of the slave
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 0;
        end while (rvalid !== 1'b1);
        v = rdata; r = rresp; rready <= 0;
    endtask : rd
    task finish_test;
        if (err_total == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    logic [1:0] r;
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        wt(10); aresetn <= 1;
        rd(`SSS_STOPT_OFS, d, r); chk(d, 32'h3e8);
        rd(`SSS_STAT_OFS, d, r); chk(d, 32'h8001);
        rd(8'h18, d, r); chk(r, 2'h2);
        // Hold stop without encoder is refused and flagged
        tsh <= 1; wt(6); rd(`SSS_STAT_OFS, d, r); chk(d[4:0], 5'h01);
        rd(`SSS_ERR_OFS, d, r); chk(d[3], 1'b1);
        tsh <= 0; wt(4); wr(`SSS_ERR_OFS, 32'hf);
        wr(`SSS_STOPT_OFS, 32'h8); wr(`SSS_CTRL_OFS, 32'h14);
        // Muted emergency stop, then unmuted immediate cutoff
        mute <= 1; estop <= 1; wt(8); chk(torque_en, 1'b1);
        mute <= 0; run <= 1; wt(8); chk(torque_en, 1'b0);
        chk(stat_b15, 1'b0);
        estop <= 0; run <= 0; wt(100); chk(torque_en, 1'b1);
        // Mode 0 at standstill: cut only when the stop time ends
        tsc <= 1; wt(12); chk(torque_en, 1'b1);
        wt(33); chk(torque_en, 1'b0); chk(err_msg, 1'b0);
        tsc <= 0; wt(10);
        // Mode 0 still moving: error stop at stop time
        run <= 1; wt(4); tsc <= 1; wt(45); chk(torque_en, 1'b0);
        chk(err_msg, 1'b1);
        rd(`SSS_ERR_OFS, d, r); chk(d[0], 1'b1);
        tsc <= 0; run <= 0; wt(100);
        wr(`SSS_ERR_OFS, 32'hf); wt(10); chk(torque_en, 1'b1);
        // Mode 1: cut after the standstill delay, before the stop time
        wr(`SSS_DELAY_OFS, 32'h1); wr(`SSS_CTRL_OFS, 32'h16);
        tsc <= 1; wt(16); chk(torque_en, 1'b0);
        finish_test;
    end
endmodule : testbench

// ===== verilog/sss_seq.sv
// Safety stop sequencer with AXI4-Lite register slave
// Function
// - Emergency stop overrides every other state, mode and stop function.
// - Emergency stop selects immediate torque cutoff or timed stop by config.
// - Muted emergency stop source has no effect.
// - Timed stop requested by bus, safe input, error stop or emergency stop.
// - Mode 0 cuts torque at stop time; mode 1 cuts at standstill.
// - Mode 0 cuts at stop time whether or not at standstill.
// - Mode 1 starts delay timer at standstill, cuts when it expires.
// - Mode 1 cuts at stop time if delay would run past it.
// - Standstill while measured speed is below tolerance window.
// - Speed from encoder if present, else inverter standstill status.
// - After stop time or standstill, power for rotating field is cut.
// - No standstill at stop time raises error, error stop and cutoff.
// - Enabled ramp monitoring exceeded raises error and error stop.
// - Withdrawing the request does not abort a running error stop.
// - Restart only after full stop time, unless special operation.
// - Deceleration ramp monitoring is configurable for the timed stop.
// - Timed hold stop checks standstill within stop time, then hold or cut.
// - Held stop keeps torque and control active at reached position.
// - Timed hold stop refused without a configured encoder.
// - Torque cutoff clears bit 15 of the drive status word.
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "sss_regs.svh"
module sss_seq #(
    parameter int TICK_CYCLES = `SSS_TICK_NS / `SSS_CLK_NS
) (
    // Clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Asynchronous request and status pins
    input  wire logic        estop_in,
    input  wire logic        tsc_in,
    input  wire logic        tsh_in,
    input  wire logic        err_stop_in,
    input  wire logic        estop_mute,
    input  wire logic        inv_standstill,
    input  wire logic        ramp_exceeded,
    // Encoder speed magnitude, same clock
    input  wire logic [15:0] enc_speed,
    // Drive outputs
    output logic             torque_en,
    output logic             hold_active,
    output logic             stat_b15,
    output logic             err_msg,
    output logic             restart_ok
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    sss_pkg::sss_pins_s  pin_s;
    sss_pkg::sss_ctrl_s  ctrl_reg;
    sss_pkg::sss_state_e state_reg;
    sss_pkg::sss_state_e state_next;
    logic [15:0] stopt_reg;
    logic [15:0] delay_reg;
    logic [15:0] tol_reg;
    logic [3:0]  err_reg;
    logic [3:0]  err_set;
    logic [3:0]  err_clr;
    logic        err_act_reg;
    logic [14:0] tick_cnt_reg;
    logic        tick_reg;
    logic        still;
    logic        estop_any;
    logic        estop_cut;
    logic        tsc_req;
    logic        tsh_raw;
    logic        tsh_req;
    logic        any_req;
    logic        stop_done;
    logic        dly_done;
    logic        stop_start;
    logic        dly_start;
    logic        leave_ok;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wr_go;
    logic [31:0] rd_word;
    logic        rd_hit;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    sss_sync #(
        .W       (7)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .din     ({estop_in, tsc_in, tsh_in, err_stop_in, estop_mute,
                   inv_standstill, ramp_exceeded}),
        .dout    (pin_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Timer tick from the device clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_reg <= 15'h0000;
            tick_reg     <= 1'b0;
        end else if (ce) begin
            tick_reg <= (tick_cnt_reg == 15'(TICK_CYCLES - 1));
            if (tick_cnt_reg == 15'(TICK_CYCLES - 1))
                tick_cnt_reg <= 15'h0000;
            else
                tick_cnt_reg <= tick_cnt_reg + 15'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Standstill and request decode
    always_comb begin
        if (ctrl_reg.enc_present)
            still = (enc_speed < tol_reg);
        else
            still = pin_s.inv_still;
        estop_any = (pin_s.estop | ctrl_reg.bus_estop) & ~pin_s.mute;
        estop_cut = estop_any & ~ctrl_reg.estop_timed;
        tsc_req   = ctrl_reg.bus_tsc | pin_s.tsc | err_act_reg
                  | (estop_any & ctrl_reg.estop_timed);
        tsh_raw   = ctrl_reg.bus_tsh | pin_s.tsh;
        tsh_req   = tsh_raw & ctrl_reg.enc_present;
        any_req   = estop_any | tsc_req | tsh_raw | pin_s.err;
        leave_ok  = !any_req && (restart_ok || ctrl_reg.special_op);
    end

    ////////////////////////////////////////////////////////////////////////
    // Stop and delay timers
    assign stop_start = (state_reg == sss_pkg::ST_IDLE);
    assign dly_start  = !(state_reg == sss_pkg::ST_TSC && ctrl_reg.mode
                          && still);

    sss_timer u_stop_tmr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .start   (stop_start),
        .run     (1'b1),
        .tick    (tick_reg),
        .limit   (stopt_reg),
        .done    (stop_done)
    );

    sss_timer u_dly_tmr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .start   (dly_start),
        .run     (1'b1),
        .tick    (tick_reg),
        .limit   (delay_reg),
        .done    (dly_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Error events
    always_comb begin
        err_set = 4'h0;
        err_set[`SSS_ERR_TIME] = stop_done && !still
            && (state_reg == sss_pkg::ST_TSC
                || state_reg == sss_pkg::ST_TSH);
        err_set[`SSS_ERR_RAMP] = ctrl_reg.ramp_en && pin_s.ramp_exc
            && (state_reg == sss_pkg::ST_TSC
                || state_reg == sss_pkg::ST_TSH);
        err_set[`SSS_ERR_EXT] = pin_s.err;
        err_set[`SSS_ERR_REFUSE] = tsh_raw && !ctrl_reg.enc_present;
        err_clr = 4'h0;
        if (wr_go && awaddr_reg == `SSS_ERR_OFS && wstrb_reg[0])
            err_clr = wdata_reg[3:0];
    end

    // Sticky flags, write one to clear, a new event wins
    always_ff @(posedge aclk) begin
        if (!aresetn)
            err_reg <= 4'h0;
        else if (ce)
            err_reg <= (err_reg & ~err_clr) | err_set;
    end

    // Error stop in progress, held until the cutoff is reached
    always_ff @(posedge aclk) begin
        if (!aresetn)
            err_act_reg <= 1'b0;
        else if (ce) begin
            if (|err_set[2:0])
                err_act_reg <= 1'b1;
            else if (state_reg == sss_pkg::ST_CUT && !pin_s.err)
                err_act_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            sss_pkg::ST_IDLE: begin
                if (estop_cut)
                    state_next = sss_pkg::ST_CUT;
                else if (tsc_req)
                    state_next = sss_pkg::ST_TSC;
                else if (tsh_req)
                    state_next = sss_pkg::ST_TSH;
            end
            sss_pkg::ST_TSC: begin
                if (estop_cut)
                    state_next = sss_pkg::ST_CUT;
                else if (stop_done)
                    state_next = sss_pkg::ST_CUT;
                else if (ctrl_reg.mode && dly_done)
                    state_next = sss_pkg::ST_CUT;
            end
            sss_pkg::ST_TSH: begin
                if (estop_cut || (stop_done && !still))
                    state_next = sss_pkg::ST_CUT;
                else if (tsc_req)
                    state_next = sss_pkg::ST_TSC;
                else if (still)
                    state_next = sss_pkg::ST_HOLD;
            end
            sss_pkg::ST_HOLD: begin
                if (estop_cut)
                    state_next = sss_pkg::ST_CUT;
                else if (tsc_req)
                    state_next = sss_pkg::ST_TSC;
                else if (leave_ok)
                    state_next = sss_pkg::ST_IDLE;
            end
            sss_pkg::ST_CUT: begin
                if (leave_ok && !err_act_reg)
                    state_next = sss_pkg::ST_IDLE;
            end
            default: state_next = sss_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn)
            state_reg <= sss_pkg::ST_IDLE;
        else if (ce)
            state_reg <= state_next;
    end

    // Drive outputs follow the next state so they align with it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            torque_en   <= 1'b1;
            hold_active <= 1'b0;
            stat_b15    <= 1'b1;
            err_msg     <= 1'b0;
        end else if (ce) begin
            torque_en   <= (state_next != sss_pkg::ST_CUT);
            hold_active <= (state_next == sss_pkg::ST_HOLD);
            stat_b15    <= (state_next != sss_pkg::ST_CUT);
            err_msg     <= |((err_reg & ~err_clr) | err_set);
        end
    end

    // Restart permission once the full stop time has run
    always_ff @(posedge aclk) begin
        if (!aresetn)
            restart_ok <= 1'b0;
        else if (ce) begin
            if (stop_start)
                restart_ok <= 1'b0;
            else if (stop_done)
                restart_ok <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_reg    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                unique case (awaddr_reg)
                    `SSS_CTRL_OFS, `SSS_STOPT_OFS, `SSS_DELAY_OFS,
                    `SSS_TOL_OFS, `SSS_STAT_OFS, `SSS_ERR_OFS:
                        s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Configuration registers with byte strobes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg  <= `SSS_CTRL_RST;
            stopt_reg <= `SSS_STOPT_RST;
            delay_reg <= `SSS_DELAY_RST;
            tol_reg   <= `SSS_TOL_RST;
        end else if (ce && wr_go) begin
            if (awaddr_reg == `SSS_CTRL_OFS && wstrb_reg[0])
                ctrl_reg <= wdata_reg[7:0];
            if (awaddr_reg == `SSS_STOPT_OFS) begin
                if (wstrb_reg[0]) stopt_reg[7:0]  <= wdata_reg[7:0];
                if (wstrb_reg[1]) stopt_reg[15:8] <= wdata_reg[15:8];
            end
            if (awaddr_reg == `SSS_DELAY_OFS) begin
                if (wstrb_reg[0]) delay_reg[7:0]  <= wdata_reg[7:0];
                if (wstrb_reg[1]) delay_reg[15:8] <= wdata_reg[15:8];
            end
            if (awaddr_reg == `SSS_TOL_OFS) begin
                if (wstrb_reg[0]) tol_reg[7:0]  <= wdata_reg[7:0];
                if (wstrb_reg[1]) tol_reg[15:8] <= wdata_reg[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr)
            `SSS_CTRL_OFS:  rd_word[7:0]  = ctrl_reg;
            `SSS_STOPT_OFS: rd_word[15:0] = stopt_reg;
            `SSS_DELAY_OFS: rd_word[15:0] = delay_reg;
            `SSS_TOL_OFS:   rd_word[15:0] = tol_reg;
            `SSS_STAT_OFS: begin
                rd_word[`SSS_STAT_ST_LSB +: 5]  = state_reg;
                rd_word[`SSS_STAT_RST_BIT]      = restart_ok;
                rd_word[`SSS_STAT_B15_BIT]      = stat_b15;
                rd_word[`SSS_STAT_ERR_BIT]      = err_act_reg;
            end
            `SSS_ERR_OFS:   rd_word[3:0]  = err_reg;
            default:        rd_hit        = 1'b0;
        endcase
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_hit ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    estop_cut_a: assert property (ce && estop_cut |=> !torque_en && !stat_b15)
        else $error("emergency cutoff not taken");
    mute_gate_a: assert property (pin_s.mute |-> !estop_any)
        else $error("muted emergency stop acted");
    tsc_entry_a: assert property (ce && state_reg == sss_pkg::ST_IDLE
        && !estop_cut && tsc_req |=> state_reg == sss_pkg::ST_TSC)
        else $error("timed stop not entered");
    mode0_cut_a: assert property (ce && state_reg == sss_pkg::ST_TSC
        && stop_done |=> state_reg == sss_pkg::ST_CUT && !torque_en)
        else $error("no cutoff at stop time");
    delay_cut_a: assert property (ce && state_reg == sss_pkg::ST_TSC
        && ctrl_reg.mode && dly_done |=> state_reg == sss_pkg::ST_CUT)
        else $error("no cutoff after delay");
    time_err_a: assert property (ce && state_reg == sss_pkg::ST_TSC
        && stop_done && !still |=> err_reg[`SSS_ERR_TIME] && err_act_reg)
        else $error("stop time fault not flagged");
    ramp_err_a: assert property (ce && state_reg == sss_pkg::ST_TSC
        && ctrl_reg.ramp_en && pin_s.ramp_exc |=> err_reg[`SSS_ERR_RAMP])
        else $error("ramp fault not flagged");
    err_keep_a: assert property (ce && err_act_reg
        && state_reg != sss_pkg::ST_CUT |=> err_act_reg)
        else $error("error stop aborted early");
    no_restart_a: assert property (ce && state_reg == sss_pkg::ST_CUT
        && !restart_ok && !ctrl_reg.special_op
        |=> state_reg == sss_pkg::ST_CUT)
        else $error("restart before stop time");
    hold_torque_a: assert property (state_reg == sss_pkg::ST_HOLD
        |-> torque_en && hold_active)
        else $error("held stop lost torque");
    tsh_refuse_a: assert property (ce && state_reg == sss_pkg::ST_IDLE
        && !ctrl_reg.enc_present && !estop_any && !tsc_req
        |=> state_reg != sss_pkg::ST_TSH)
        else $error("hold stop without encoder");
endmodule : sss_seq

// ===== verilog/sss_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sss_sync #(
    parameter int W = 7
) (
    // Clock and control
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_reg;

    // First flop feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            dout     <= '0;
        end else if (ce) begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule : sss_sync

// ===== verilog/sss_timer.sv
// Tick-counting timer with a level done flag
`timescale 1ns/1ps
module sss_timer (
    // Clock and control
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // Timer control
    input  wire logic        start,
    input  wire logic        run,
    input  wire logic        tick,
    input  wire logic [15:0] limit,
    // Result
    output logic             done
);
    logic [15:0] cnt_reg;

    // Clear on start, count ticks while running, stick at done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 16'h0000;
            done    <= 1'b0;
        end else if (ce) begin
            if (start) begin
                cnt_reg <= 16'h0000;
                done    <= 1'b0;
            end else if (run && tick && !done) begin
                cnt_reg <= cnt_reg + 16'h0001;
                if (cnt_reg + 16'h0001 >= limit)
                    done <= 1'b1;
            end
        end
    end

    // A running timer never counts past its limit
    limit_reach_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && run && tick && !start && !done && cnt_reg + 16'h0001 >= limit
        |=> done) else $error("timer missed its limit");
endmodule : sss_timer
